/* verilog/pducfg_pkg.sv */
// Shared constants and state enumerations for the configuration message handler
package pducfg_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
   localparam int STEP_DELAY_MAX_MS = 5000;
   localparam int NUM_OUT = 8;
   localparam int MSG_BUF = 35;
   localparam logic [7:0] OP_SET_GROUP = 8'h92;
   localparam logic [7:0] OP_GROUP_ACK = 8'h93;
   localparam logic [7:0] OP_STARTUP = 8'h94;
   localparam logic [7:0] OP_STARTUP_ACK = 8'h95;
   localparam logic [7:0] OP_INPUT = 8'h96;
   localparam logic [7:0] OP_INPUT_ACK = 8'h97;
   localparam logic [7:0] OP_ADDR = 8'h98;
   localparam logic [7:0] OP_ADDR_ACK = 8'h99;
   localparam logic [7:0] OP_CFG_REQ = 8'h9a;
   localparam logic [7:0] OP_CFG_RSP = 8'h9b;
   localparam logic [15:0] LEN_MIN = 16'h0003;
   localparam logic [15:0] LEN_GROUP = 16'h000c;
   localparam logic [15:0] LEN_STARTUP = 16'h001b;
   localparam logic [15:0] LEN_INPUT = 16'h0023;
   localparam logic [15:0] LEN_ADDR = 16'h000c;
   localparam logic [15:0] LEN_CFG_REQ = 16'h0003;
   localparam logic [6:0] LEN_ACK = 7'h04;
   localparam logic [6:0] LEN_CFG_RSP = 7'h7d;
   localparam logic [7:0] ST_ACK = 8'h00;
   localparam logic [7:0] ST_NACK = 8'h01;
   localparam logic [7:0] ST_WP = 8'h02;
   localparam logic [7:0] SEL_TERM = 8'h00;
   localparam logic [7:0] GRP_NONE = 8'hff;
   localparam logic [7:0] MODE_STATIC = 8'h01;
   // Byte positions inside received messages
   localparam int F_GRP_ID = 3;
   localparam int F_GRP_CH = 4;
   localparam int F_DCI_ST = 11;
   localparam int F_POR_DLY = 11;
   localparam int F_DCI_DLY = 19;
   // Byte positions inside the readback reply
   localparam int R_IP = 4;
   localparam int R_MASK = 8;
   localparam int R_MODE = 12;
   localparam int R_GRP = 61;
   localparam int R_POR_SEL = 69;
   localparam int R_POR_DLY = 77;
   localparam int R_DCI_SEL = 93;
   localparam int R_DCI_ST = 101;
   localparam int R_DCI_DLY = 109;
   // Wishbone register byte addresses
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_IP = 8'h08;
   localparam logic [7:0] ADR_MASK = 8'h0c;
   localparam int CTRL_START_BIT = 0;
   localparam logic [31:0] RST_IP = 32'h0000_0000;
   localparam logic [31:0] RST_MASK = 32'h0000_0000;
   localparam logic [7:0] RST_MODE = 8'h00;
   typedef enum logic {R_RX, R_TX} pducfg_rx_t;
   typedef enum logic {Q_IDLE, Q_WAIT} pducfg_seq_t;
endpackage : pducfg_pkg

/* verilog/pducfg_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pducfg_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   if (W < 1) $error("pducfg_sync: width below one");
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         meta_q <= '0;
         q_o <= '0;
      end
      else
      begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : pducfg_sync

/* verilog/pducfg_tick.sv */
// Millisecond enable divider, restartable so step delays start on a clean phase
`timescale 1ns/1ps
module pducfg_tick #(
   parameter int DIV = 50000
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic clr_i,
   output logic tick_o
);
   logic [31:0] cnt_q;
   if (DIV < 2) $error("pducfg_tick: divider below two");
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i || clr_i)
      begin
         cnt_q <= '0;
         tick_o <= 1'b0;
      end
      else if (cnt_q == 32'(DIV - 1))
      begin
         cnt_q <= '0;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 32'd1;
         tick_o <= 1'b0;
      end
   end
endmodule : pducfg_tick

/* verilog/pducfg_handler.sv */
// Configuration message handler: parser, acknowledge replies, store, sequencer, Wishbone
// Operation
// RULE1: opcode byte then length counting whole message
// RULE2: group assignment answered 0x93, length four
// RULE3: startup macro 0x94 stores power-up list
// RULE4: eight selectors paired with eight delays
// RULE5: selectors 1-8 outputs, 129-136 groups, zero ends
// RULE6: repeated startup channel acts first time only
// RULE7: startup waits paired delay before each enable
// RULE8: input macro 0x96 runs on wake short
// RULE9: input macro walks selectors in order
// RULE10: state entry zero off, one on
// RULE11: input step waits its paired delay
// RULE12: replies 0x95/0x97/0x99 with ack, nack, protected
// RULE13: address message sets mode and address
// RULE14: mode zero dynamic, one static
// RULE15: address then mask, any value taken
// RULE16: readback returns whole stored configuration
// RULE17: readback 0x9a answered 0x9b, length 125
// RULE18: programmable output to group table
// RULE19: wrong length gets nack, nothing stored
`timescale 1ns/1ps
module pducfg_handler #(
   parameter int CYC_PER_MS = pducfg_pkg::CYC_PER_MS
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   output logic rx_ready_o,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   input wire logic wake_discrete_input_i,
   input wire logic write_protect_i,
   output logic [7:0] out_en_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   if (CYC_PER_MS < 2) $error("pducfg_handler: CYC_PER_MS below two");

   typedef struct packed {
      pducfg_pkg::pducfg_rx_t st;
      logic rx_rdy;
      logic [15:0] cnt;
      logic [15:0] len;
      logic [34:0][7:0] mbuf;
      logic [6:0] tx_idx;
      logic [6:0] tx_len;
      logic tx_vld;
      logic [7:0] tx_dat;
      logic [7:0] rsp_op;
      logic [7:0] rsp_st;
      logic [7:0][7:0] grp;
      logic [7:0][7:0] por_sel;
      logic [7:0][15:0] por_dly;
      logic [7:0][7:0] dci_sel;
      logic [7:0][7:0] dci_st;
      logic [7:0][15:0] dci_dly;
      logic [31:0] ip;
      logic [31:0] mask;
      logic [7:0] mode;
      pducfg_pkg::pducfg_seq_t seq;
      logic seq_dci;
      logic [3:0] idx;
      logic [15:0] ms;
      logic [7:0] out;
      logic boot;
      logic wake_d;
      logic wb_ack;
      logic [31:0] wb_dat;
   } pducfg_state_t;

   pducfg_state_t s_q;
   pducfg_state_t s_d;
   logic [1:0] pins_s;
   logic wake_s;
   logic wp_s;
   logic tick;
   logic tick_clr;
   logic acc;
   logic done;
   logic ok_len;
   logic known;
   logic dup;
   logic seq_end;
   logic apply;
   logic req;
   logic grp_live;
   logic [7:0] op;
   logic [7:0] cur_sel;
   logic [15:0] cur_dly;
   logic [15:0] len_now;
   logic [15:0] exp_len;
   logic [34:0][7:0] b;
   logic [7:0][7:0] sel_in;

   pducfg_sync #(.W(2)) u_sync (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .d_i({wake_discrete_input_i, write_protect_i}),
      .q_o(pins_s)
   );
   assign wake_s = pins_s[1];
   assign wp_s = pins_s[0];

   pducfg_tick #(.DIV(CYC_PER_MS)) u_tick (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .clr_i(tick_clr),
      .tick_o(tick)
   );

   // Outputs named by selector: single output or every member of a group
   function automatic logic [7:0] targets(input logic [7:0] sel, input logic [7:0][7:0] grp);
      logic [7:0] t;
      t = '0;
      for (int k = 0; k < pducfg_pkg::NUM_OUT; k++)
      begin
         if (!sel[7] && sel[6:0] == 7'(k + 1))
            t[k] = 1'b1; // RULE5
         if (sel[7] && sel[6:0] >= 7'd1 && sel[6:0] <= 7'd8 && grp[k] == {1'b0, sel[6:0]})
            t[k] = 1'b1; // RULE18
      end
      return t;
   endfunction : targets

   // Reply byte n; readback layout is fixed, limit fields are not held here and read zero
   function automatic logic [7:0] resp_byte(input pducfg_state_t s, input logic [6:0] i);
      logic [7:0] r;
      int n;
      r = 8'h00;
      n = int'(i);
      if (n == 0) r = s.rsp_op;
      else if (n == 2) r = {1'b0, s.tx_len};
      else if (n == 3) r = s.rsp_st;
      else if (n >= pducfg_pkg::R_IP && n < pducfg_pkg::R_MASK) r = s.ip[8*(7-n) +: 8]; // RULE16
      else if (n >= pducfg_pkg::R_MASK && n < pducfg_pkg::R_MODE) r = s.mask[8*(11-n) +: 8];
      else if (n == pducfg_pkg::R_MODE) r = s.mode; // RULE17
      else if (n >= pducfg_pkg::R_GRP && n < pducfg_pkg::R_POR_SEL) r = s.grp[n-61];
      else if (n >= pducfg_pkg::R_POR_SEL && n < pducfg_pkg::R_POR_DLY) r = s.por_sel[n-69];
      else if (n >= pducfg_pkg::R_POR_DLY && n < pducfg_pkg::R_DCI_SEL)
         r = s.por_dly[(n-77)/2][8*(1-(n-77)%2) +: 8];
      else if (n >= pducfg_pkg::R_DCI_SEL && n < pducfg_pkg::R_DCI_ST) r = s.dci_sel[n-93];
      else if (n >= pducfg_pkg::R_DCI_ST && n < pducfg_pkg::R_DCI_DLY) r = s.dci_st[n-101];
      else if (n >= pducfg_pkg::R_DCI_DLY) r = s.dci_dly[(n-109)/2][8*(1-(n-109)%2) +: 8];
      return r;
   endfunction : resp_byte

   always_comb
   begin
      s_d = s_q;
      grp_live = 1'b1;
      acc = rx_valid_i && s_q.rx_rdy;
      b = s_q.mbuf;
      if (acc && s_q.cnt < 16'(pducfg_pkg::MSG_BUF))
         b[s_q.cnt[5:0]] = rx_data_i;
      op = b[0];
      sel_in = b[10:3];
      len_now = (s_q.cnt == 16'd2) ? {b[1], b[2]} : s_q.len; // RULE1
      done = acc && s_q.cnt >= 16'd2 &&
             (s_q.cnt + 16'd1) >= ((len_now < pducfg_pkg::LEN_MIN) ? pducfg_pkg::LEN_MIN : len_now);
      known = 1'b1;
      case (op)
         pducfg_pkg::OP_SET_GROUP: exp_len = pducfg_pkg::LEN_GROUP;
         pducfg_pkg::OP_STARTUP: exp_len = pducfg_pkg::LEN_STARTUP;
         pducfg_pkg::OP_INPUT: exp_len = pducfg_pkg::LEN_INPUT;
         pducfg_pkg::OP_ADDR: exp_len = pducfg_pkg::LEN_ADDR;
         pducfg_pkg::OP_CFG_REQ: exp_len = pducfg_pkg::LEN_CFG_REQ;
         default:
         begin
            exp_len = 16'h0000;
            known = 1'b0;
         end
      endcase
      ok_len = known && len_now == exp_len;
      // Receive side
      if (acc)
      begin
         s_d.mbuf = b;
         s_d.cnt = s_q.cnt + 16'd1;
         s_d.len = len_now;
      end
      if (done)
      begin
         s_d.st = pducfg_pkg::R_TX;
         s_d.rx_rdy = 1'b0;
         s_d.tx_vld = 1'b1;
         s_d.tx_idx = '0;
         s_d.tx_len = pducfg_pkg::LEN_ACK;
         s_d.cnt = '0;
         s_d.rsp_op = op + 8'h01; // RULE12
         s_d.tx_dat = op + 8'h01;
         s_d.rsp_st = pducfg_pkg::ST_ACK;
         if (!ok_len)
            s_d.rsp_st = pducfg_pkg::ST_NACK; // RULE19
         else
         begin
            case (op)
               pducfg_pkg::OP_SET_GROUP:
               begin
                  if (b[3] >= 8'd1 && b[3] <= 8'd8)
                  begin
                     // Applied even when protected; only persistence is lost
                     for (int k = 0; k < 8; k++)
                        if (s_q.grp[k] == b[pducfg_pkg::F_GRP_ID])
                           s_d.grp[k] = pducfg_pkg::GRP_NONE; // RULE18
                     for (int j = 0; j < 8; j++)
                     begin
                        // List ends at its first zero, later entries ignored
                        if (b[pducfg_pkg::F_GRP_CH+j] == 8'h00)
                           grp_live = 1'b0;
                        if (grp_live && b[pducfg_pkg::F_GRP_CH+j] <= 8'd8)
                           s_d.grp[3'(b[pducfg_pkg::F_GRP_CH+j] - 8'd1)] = b[3];
                     end
                     s_d.rsp_st = wp_s ? pducfg_pkg::ST_WP : pducfg_pkg::ST_ACK; // RULE2
                  end
                  else
                     s_d.rsp_st = pducfg_pkg::ST_NACK;
               end
               pducfg_pkg::OP_STARTUP:
               begin
                  if (wp_s)
                     s_d.rsp_st = pducfg_pkg::ST_WP; // RULE12
                  else
                  begin
                     s_d.por_sel = sel_in; // RULE3
                     for (int j = 0; j < 8; j++)
                        s_d.por_dly[j] = {b[pducfg_pkg::F_POR_DLY+2*j], b[12+2*j]}; // RULE4
                  end
               end
               pducfg_pkg::OP_INPUT:
               begin
                  if (wp_s)
                     s_d.rsp_st = pducfg_pkg::ST_WP;
                  else
                  begin
                     s_d.dci_sel = sel_in; // RULE8
                     s_d.dci_st = b[18:11]; // RULE10
                     for (int j = 0; j < 8; j++)
                        s_d.dci_dly[j] = {b[pducfg_pkg::F_DCI_DLY+2*j], b[20+2*j]}; // RULE11
                  end
               end
               pducfg_pkg::OP_ADDR:
               begin
                  if (b[3] > pducfg_pkg::MODE_STATIC)
                     s_d.rsp_st = pducfg_pkg::ST_NACK; // RULE14
                  else if (wp_s)
                     s_d.rsp_st = pducfg_pkg::ST_WP;
                  else
                  begin
                     s_d.mode = b[3]; // RULE13
                     s_d.ip = {b[4], b[5], b[6], b[7]}; // RULE15
                     s_d.mask = {b[8], b[9], b[10], b[11]};
                  end
               end
               default:
                  s_d.tx_len = pducfg_pkg::LEN_CFG_RSP; // RULE17
            endcase
         end
      end
      // Transmit side holds each byte until taken
      if (s_q.st == pducfg_pkg::R_TX && tx_ready_i)
      begin
         if (s_q.tx_idx + 7'd1 == s_q.tx_len)
         begin
            s_d.st = pducfg_pkg::R_RX;
            s_d.tx_vld = 1'b0;
            s_d.rx_rdy = 1'b1;
         end
         else
         begin
            s_d.tx_idx = s_q.tx_idx + 7'd1;
            s_d.tx_dat = resp_byte(s_q, s_q.tx_idx + 7'd1); // RULE16
         end
      end
      // Sequencer
      cur_sel = s_q.seq_dci ? s_q.dci_sel[s_q.idx[2:0]] : s_q.por_sel[s_q.idx[2:0]];
      cur_dly = s_q.seq_dci ? s_q.dci_dly[s_q.idx[2:0]] : s_q.por_dly[s_q.idx[2:0]];
      seq_end = s_q.idx[3] || cur_sel == pducfg_pkg::SEL_TERM; // RULE5
      dup = 1'b0;
      for (int j = 0; j < 8; j++)
         if (j < int'(s_q.idx) && s_q.por_sel[j] == cur_sel)
            dup = 1'b1; // RULE6
      apply = s_q.seq == pducfg_pkg::Q_WAIT && !seq_end &&
              ((dup && !s_q.seq_dci) || s_q.ms >= cur_dly); // RULE7
      tick_clr = s_q.seq == pducfg_pkg::Q_IDLE || apply;
      req = wb_cyc_i && wb_stb_i && !s_q.wb_ack;
      s_d.wake_d = wake_s;
      case (s_q.seq)
         pducfg_pkg::Q_IDLE:
         begin
            // A wake edge during a running sequence is not queued
            if (s_q.boot || (req && wb_we_i && wb_adr_i == pducfg_pkg::ADR_CTRL && wb_sel_i[0] &&
                wb_dat_i[pducfg_pkg::CTRL_START_BIT]))
            begin
               s_d.seq = pducfg_pkg::Q_WAIT;
               s_d.seq_dci = 1'b0;
               s_d.idx = '0;
               s_d.ms = '0;
               s_d.boot = 1'b0;
            end
            else if (wake_s && !s_q.wake_d)
            begin
               s_d.seq = pducfg_pkg::Q_WAIT; // RULE8
               s_d.seq_dci = 1'b1;
               s_d.idx = '0;
               s_d.ms = '0;
            end
         end
         pducfg_pkg::Q_WAIT:
         begin
            if (seq_end)
               s_d.seq = pducfg_pkg::Q_IDLE;
            else if (apply)
            begin
               if (!s_q.seq_dci)
                  s_d.out = s_q.out | targets(cur_sel, s_q.grp); // RULE7
               else if (s_q.dci_st[s_q.idx[2:0]] == 8'h01)
                  s_d.out = s_q.out | targets(cur_sel, s_q.grp); // RULE10
               else if (s_q.dci_st[s_q.idx[2:0]] == 8'h00)
                  s_d.out = s_q.out & ~targets(cur_sel, s_q.grp);
               s_d.idx = s_q.idx + 4'd1; // RULE9
               s_d.ms = '0;
            end
            else if (tick && s_q.ms != 16'hffff)
               s_d.ms = s_q.ms + 16'd1; // RULE11
         end
         default:
            s_d.seq = pducfg_pkg::Q_IDLE;
      endcase
      // Wishbone slave, one wait state, unmapped reads return zero
      s_d.wb_ack = req;
      if (req)
      begin
         case (wb_adr_i)
            pducfg_pkg::ADR_STATUS:
               s_d.wb_dat = {14'h0000, wp_s, s_q.seq != pducfg_pkg::Q_IDLE, s_q.mode, s_q.out};
            pducfg_pkg::ADR_IP: s_d.wb_dat = s_q.ip;
            pducfg_pkg::ADR_MASK: s_d.wb_dat = s_q.mask;
            default: s_d.wb_dat = 32'h0000_0000;
         endcase
      end
      if (!nrst_i)
      begin
         s_d = '0;
         s_d.rx_rdy = 1'b1;
         s_d.boot = 1'b1;
         s_d.grp = {8{pducfg_pkg::GRP_NONE}};
         s_d.ip = pducfg_pkg::RST_IP;
         s_d.mask = pducfg_pkg::RST_MASK;
         s_d.mode = pducfg_pkg::RST_MODE;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      s_q <= s_d;
   end

   assign rx_ready_o = s_q.rx_rdy;
   assign tx_valid_o = s_q.tx_vld;
   assign tx_data_o = s_q.tx_dat;
   assign out_en_o = s_q.out;
   assign wb_dat_o = s_q.wb_dat;
   assign wb_ack_o = s_q.wb_ack;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   sequence s_msg_done(logic [7:0] o);
      done && op == o && ok_len;
   endsequence

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_ack_answer: assert property (req |=> wb_ack_o) else $error("bus request not answered");
   a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) // RULE1
      else $error("reply byte dropped");
   a_len_nack: assert property (done && known && !ok_len |=> s_q.rsp_st == pducfg_pkg::ST_NACK // RULE19
      && tx_valid_o && !rx_ready_o) else $error("length mismatch not refused");
   a_group_reply: assert property (s_msg_done(pducfg_pkg::OP_SET_GROUP) |=> s_q.tx_len == 7'd4 // RULE2
      && tx_data_o == pducfg_pkg::OP_GROUP_ACK) else $error("group reply wrong");
   a_startup_store: assert property (s_msg_done(pducfg_pkg::OP_STARTUP) ##0 !wp_s // RULE3
      |=> s_q.por_sel == $past(sel_in)) else $error("startup list not stored");
   a_wp_keep: assert property (s_msg_done(pducfg_pkg::OP_STARTUP) ##0 wp_s // RULE12
      |=> $stable(s_q.por_sel) && s_q.rsp_st == pducfg_pkg::ST_WP) else $error("protect ignored");
   a_term_stop: assert property (s_q.seq == pducfg_pkg::Q_WAIT && seq_end // RULE5
      |=> s_q.seq == pducfg_pkg::Q_IDLE) else $error("sequence ran past end");
   a_dup_skip: assert property (s_q.seq == pducfg_pkg::Q_WAIT && !seq_end && dup // RULE6
      && !s_q.seq_dci |=> $stable(out_en_o)) else $error("repeat channel acted on");
   a_step_delay: assert property ($changed(out_en_o) |-> $past(s_q.ms) >= $past(cur_dly)) // RULE7
      else $error("output switched before delay");
   a_mode_static: assert property (s_msg_done(pducfg_pkg::OP_ADDR) ##0 !wp_s // RULE14
      ##0 b[3] == 8'h01 |=> s_q.mode == pducfg_pkg::MODE_STATIC)
      else $error("static mode not taken");
endmodule : pducfg_handler

/* tb/pducfg_host_model.sv */
// Host controller model: sends message bytes and collects reply bytes
`timescale 1ns/1ps
module pducfg_host_model (
   input wire logic clk_sys_i,
   input wire logic rx_ready_i,
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o
);
   logic slow = 1'b0;
   initial
   begin
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
      tx_ready_o = 1'b1;
   end
   // Slow mode drops ready on every other clock cycle, so each reply byte after the first waits one extra cycle
   always @(posedge clk_sys_i)
      tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
   task automatic send(input logic [7:0] m[$]);
      foreach (m[i])
      begin
         rx_valid_o <= 1'b1;
         rx_data_o <= m[i];
         do @(posedge clk_sys_i); while (rx_ready_i !== 1'b1);
      end
      rx_valid_o <= 1'b0;
      // Released line must not keep showing the last byte
      rx_data_o <= ~m[m.size()-1];
   endtask : send
   task automatic recv(output logic [7:0] r[$]);
      int n;
      r = {};
      n = 0;
      while (n < 2000 && !(r.size() > 2 && r.size() == {r[1], r[2]}))
      begin
         @(posedge clk_sys_i);
         n++;
         if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
            r.push_back(tx_data_i);
      end
   endtask : recv
endmodule : pducfg_host_model

/* tb/testbench.sv */
// Self-checking bench for the configuration message handler
`timescale 1ns/1ps
module testbench;
   localparam int CPM = 4;
   logic clk_sys_i, nrst_i, rx_valid, rx_ready, tx_valid, tx_ready, wake, wp;
   logic wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] rx_data, tx_data, out_en, wb_adr;
   logic [31:0] wb_dat, wb_q, rd;
   logic [3:0] wb_sel;
   logic [7:0] m[$];
   logic [7:0] r[$];
   int n_errors = 0;
   int cmp_count = 0;
   int c;
   pducfg_handler #(.CYC_PER_MS(CPM)) u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_ready_o(rx_ready),
      .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
      .wake_discrete_input_i(wake), .write_protect_i(wp), .out_en_o(out_en),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack));
   pducfg_host_model u_host (.clk_sys_i(clk_sys_i), .rx_ready_i(rx_ready),
      .rx_valid_o(rx_valid), .rx_data_o(rx_data), .tx_valid_i(tx_valid),
      .tx_data_i(tx_data), .tx_ready_o(tx_ready));
   initial
   begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // Classic cycle; waits for ack, no fixed latency assumed
   task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 50);
      chk("wb_ack", {31'h0, wb_ack}, 32'd1);
      rd = wb_q;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_sys_i);
   endtask : wbx
   task automatic xfer;
      u_host.send(m);
      u_host.recv(r);
   endtask : xfer
   task automatic ack_chk(input logic [7:0] op, input logic [7:0] st);
      chk("reply_op", r[0], op);
      chk("reply_len", {r[1], r[2]}, 32'd4);
      chk("reply_status", r[3], st);
   endtask : ack_chk
   task automatic wait_chg;
      logic [7:0] p;
      p = out_en;
      c = 0;
      while (out_en === p && c < 500)
      begin
         @(posedge clk_sys_i);
         c++;
      end
   endtask : wait_chg
   task automatic t_addr(input logic [7:0] md, input logic [31:0] ip, input logic [7:0] st,
                         input logic [31:0] ip_x, input logic [7:0] md_x);
      m = {8'h98, 8'h00, 8'h0c, md, ip[31:24], ip[23:16], ip[15:8], ip[7:0],
           ~ip[31:24], ~ip[23:16], ~ip[15:8], ~ip[7:0]};
      xfer();
      ack_chk(pducfg_pkg::OP_ADDR_ACK, st);
      wbx(1'b0, pducfg_pkg::ADR_IP, 32'h0);
      chk("ip", rd, ip_x);
      wbx(1'b0, pducfg_pkg::ADR_MASK, 32'h0);
      chk("mask", rd, ~ip_x);
      wbx(1'b0, pducfg_pkg::ADR_STATUS, 32'h0);
      chk("mode", rd[15:8], md_x);
      $display("test address mode %h done", md);
   endtask : t_addr
   task automatic t_badlen;
      m = {8'h98, 8'h00, 8'h0d, 8'h01};
      repeat (9) m.push_back(8'hee);
      xfer();
      ack_chk(pducfg_pkg::OP_ADDR_ACK, pducfg_pkg::ST_NACK);
      wbx(1'b0, pducfg_pkg::ADR_IP, 32'h0);
      chk("ip_kept", rd, 32'h0a000001);
      $display("test bad length done");
   endtask : t_badlen
   task automatic t_group(input logic [7:0] st);
      m = {8'h92, 8'h00, 8'h0c, 8'h01, 8'h03, 8'h05};
      repeat (6) m.push_back(8'h00);
      xfer();
      ack_chk(pducfg_pkg::OP_GROUP_ACK, st);
      $display("test group done");
   endtask : t_group
   task automatic t_readback;
      m = {8'h9a, 8'h00, 8'h03};
      u_host.slow = 1'b1;
      xfer();
      u_host.slow = 1'b0;
      chk("rb_size", r.size(), 32'd125);
      chk("rb_op", r[0], pducfg_pkg::OP_CFG_RSP);
      chk("rb_ip", {r[4], r[5], r[6], r[7]}, 32'h0a000001);
      chk("rb_mode", r[12], 8'h00);
      chk("rb_grp", {r[61], r[63], r[65]}, 24'hff0101);
      $display("test readback done");
   endtask : t_readback
   task automatic t_startup;
      m = {8'h94, 8'h00, 8'h1b, 8'h02, 8'h02, 8'h81};
      repeat (5) m.push_back(8'h00);
      m = {m, 8'h00, 8'h01, 8'h00, 8'h03, 8'h00, 8'h02};
      repeat (10) m.push_back(8'h00);
      xfer();
      ack_chk(pducfg_pkg::OP_STARTUP_ACK, pducfg_pkg::ST_ACK);
      wbx(1'b1, pducfg_pkg::ADR_CTRL, 32'h1);
      wait_chg();
      chk("startup_1", out_en, 8'h02);
      chk("startup_d1", 32'(c >= CPM - 2), 32'd1);
      wait_chg();
      chk("startup_2", out_en, 8'h16);
      // A skipped duplicate adds no 3 ms wait
      chk("startup_d2", 32'(c >= 2 * CPM && c <= 2 * CPM + 3), 32'd1);
      $display("test startup done");
   endtask : t_startup
   task automatic t_input;
      m = {8'h96, 8'h00, 8'h23, 8'h01, 8'h03};
      repeat (6) m.push_back(8'h00);
      m = {m, 8'h01};
      repeat (9) m.push_back(8'h00);
      m = {m, 8'h00, 8'h01};
      repeat (12) m.push_back(8'h00);
      xfer();
      ack_chk(pducfg_pkg::OP_INPUT_ACK, pducfg_pkg::ST_ACK);
      wake <= 1'b1;
      wait_chg();
      chk("input_1", out_en, 8'h17);
      wait_chg();
      chk("input_2", out_en, 8'h13);
      chk("input_d2", 32'(c >= CPM), 32'd1);
      wake <= 1'b0;
      $display("test input macro done");
   endtask : t_input
   initial
   begin
      nrst_i = 1'b0;
      wake = 1'b0;
      wp = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_dat = 32'h0;
      wb_sel = 4'hf;
      repeat (3) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      @(posedge clk_sys_i);
      t_addr(8'h01, 32'hc0a80107, pducfg_pkg::ST_ACK, 32'hc0a80107, 8'h01);
      t_addr(8'h00, 32'h0a000001, pducfg_pkg::ST_ACK, 32'h0a000001, 8'h00);
      t_addr(8'h02, 32'h12345678, pducfg_pkg::ST_NACK, 32'h0a000001, 8'h00);
      t_badlen();
      t_group(pducfg_pkg::ST_ACK);
      t_readback();
      t_startup();
      t_input();
      wp <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      t_addr(8'h01, 32'h01020304, pducfg_pkg::ST_WP, 32'h0a000001, 8'h00);
      t_group(pducfg_pkg::ST_WP);
      // Start bit only counts with its byte lane selected
      wb_sel <= 4'he;
      wbx(1'b1, pducfg_pkg::ADR_CTRL, 32'h1);
      wb_sel <= 4'hf;
      wbx(1'b0, pducfg_pkg::ADR_STATUS, 32'h0);
      chk("start_masked", rd[16], 1'b0);
      chk("status_wp", rd[17], 1'b1);
      $display("test masked start done");
      wbx(1'b1, 8'h40, 32'hffffffff);
      wbx(1'b0, 8'h40, 32'h0);
      chk("unmapped", rd, 32'h0);
      stop_test();
   end
   // Whole run needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      n_errors++;
      stop_test();
   end
endmodule : testbench
